// File: core/fcps_pkg.sv
// Purpose: shared constants for the flash command, protection and status block
// Assumes: 32-bit Avalon-MM slave, word-indexed registers, byte data in lane 0
// Notes: address bit 16 selects the array window, bits 15:0 the array address
package fcps_pkg;
	localparam int unsigned REG_AW        = 17;
	localparam int unsigned ARRAY_SEL     = 16;
	localparam logic [16:0] A_CONFIG      = 17'h00000;
	localparam logic [16:0] A_DIVIDER     = 17'h00001;
	localparam logic [16:0] A_PROT        = 17'h00002;
	localparam logic [16:0] A_STATUS      = 17'h00003;
	localparam logic [16:0] A_COMMAND     = 17'h00004;
	localparam logic [16:0] A_SECURITY    = 17'h00005;
	localparam int unsigned CFG_KEYEN     = 5;
	localparam int unsigned DIV_PRE       = 6;
	localparam int unsigned DIV_SET       = 7;
	localparam int unsigned PROT_DIS      = 0;
	localparam int unsigned ST_EMPTY      = 7;
	localparam int unsigned ST_DONE       = 6;
	localparam int unsigned ST_PVIOL      = 5;
	localparam int unsigned ST_ACCERR     = 4;
	localparam int unsigned ST_BLANK      = 2;
	localparam logic [7:0]  CMD_BLANK     = 8'h05;
	localparam logic [7:0]  CMD_BYTE      = 8'h20;
	localparam logic [7:0]  CMD_BURST     = 8'h25;
	localparam logic [7:0]  CMD_PAGE      = 8'h40;
	localparam logic [7:0]  CMD_MASS      = 8'h41;
	localparam logic [15:0] KEY_FIRST     = 16'hFFB0;
	localparam logic [15:0] KEY_LAST      = 16'hFFB7;
	localparam logic [15:0] NONVOLATILE_PROTECTION_BYTE_ADDR   = 16'hFFBD;
	localparam int unsigned PAGE_AW       = 9;
	localparam logic [7:0]  ERASED        = 8'hFF;
	localparam logic [7:0]  PROT_RESET    = 8'hFF;
	localparam logic [1:0]  SEC_RESET     = 2'h0;
	localparam logic [1:0]  SEC_UNSEC     = 2'h2;
	localparam logic [2:0]  PRE_LAST      = 3'h7;
	localparam int unsigned ARRAY_BYTES_D = 1024;
	localparam int unsigned PROG_PULSES_D = 9;
	localparam int unsigned PAGE_PULSES_D = 4000;
	localparam int unsigned MASS_PULSES_D = 20000;
	localparam int unsigned BLNK_PULSES_D = 1;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_DATA = 3'b010,
		SEQ_CMD  = 3'b100
	} fcps_seq_e;

	typedef enum logic [5:0] {
		EX_BOOT  = 6'b000001,
		EX_BCAP  = 6'b000010,
		EX_IDLE  = 6'b000100,
		EX_WAIT  = 6'b001000,
		EX_SWEEP = 6'b010000,
		EX_CHECK = 6'b100000
	} fcps_ex_e;

	function automatic logic fcps_legal(input logic [7:0] c);
		return (c == CMD_BLANK) || (c == CMD_BYTE) || (c == CMD_BURST) ||
			(c == CMD_PAGE) || (c == CMD_MASS);
	endfunction

	function automatic logic fcps_prot_hit(input logic [15:0] a, input logic [7:0] p,
		input logic [7:0] c);
		if (p[PROT_DIS])
			return 1'b0;
		if (c == CMD_BLANK)
			return 1'b0;
		if (c == CMD_MASS)
			return 1'b1;
		return a[15:9] > p[7:1];
	endfunction
endpackage

// File: core/fcps_mem.sv
// Purpose: byte array of the flash, registered read port
// Assumes: single clock, one write and one read per cycle
// Notes: contents start erased and are not touched by reset
`timescale 1ns/1ns
module fcps_mem #(
	parameter int unsigned DEPTH = 1024,
	parameter int unsigned AW    = 10
)(
	input  wire logic          mclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [DEPTH];

	initial
	begin
		for (int i = 0; i < DEPTH; i++)
			mem[i] = 8'hFF;
	end

	always_ff @(posedge mclk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge mclk)
	begin
		rdata <= mem[raddr];
	end
endmodule // fcps_mem

// File: core/fcps_core.sv
// Purpose: flash command launch, protection and status registers
// Assumes: software follows data, command, launch order
// Notes: no interrupt; array timing paced by the flash clock enable
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
module fcps_core #(
	parameter int unsigned ARRAY_BYTES = fcps_pkg::ARRAY_BYTES_D,
	parameter int unsigned PROG_PULSES = fcps_pkg::PROG_PULSES_D,
	parameter int unsigned PAGE_PULSES = fcps_pkg::PAGE_PULSES_D,
	parameter int unsigned MASS_PULSES = fcps_pkg::MASS_PULSES_D,
	parameter int unsigned BLNK_PULSES = fcps_pkg::BLNK_PULSES_D
)(
	input  wire logic                        mclk,
	input  wire logic                        resetn,
	input  wire logic [fcps_pkg::REG_AW-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        stop_req,
	output logic                             key_wr_valid,
	output logic      [2:0]                  key_wr_index,
	output logic      [7:0]                  key_wr_byte,
	output logic      [1:0]                  security_state_code
);
	import fcps_pkg::*;
	localparam int unsigned AW = $clog2(ARRAY_BYTES);
	localparam logic [15:0] BASE = 16'(32'h10000 - ARRAY_BYTES);
	localparam logic [AW-1:0] LAST = AW'(ARRAY_BYTES - 1);

	fcps_seq_e     seq_q;
	fcps_ex_e      ex_q;
	logic          keyen_q, div_set_q, empty_q, pviol_q, accerr_q, blank_q;
	logic [6:0]    div_q;
	logic [7:0]    prot_q, cmd_q, bc_q, bd_q, ec_q, ed_q, sd_q, mem_rdata;
	logic [15:0]   sa_q, ba_q, pulse_q;
	logic [AW-1:0] ea_q, ptr_q, end_q, raddr;
	logic [2:0]    pre_q;
	logic [5:0]    dcnt_q;
	logic [1:0]    rd_cnt_q;
	logic          stop_s1_q, stop_s2_q, blank_ok_q, chk_q, tick;
	logic          booting, active, sweep, rd_go, rd_ack, arr, key_hit, in_arr;
	logic          wr, wr_arr, wr_key, wr_cmd, wr_st, wr_prot;
	logic          launch_req, launch_err, launch_pv, launch_ok, xfer;
	logic          arr_err, cmd_err, stop_abort, acc_set, blank_done, done;
	logic [15:0]   caddr;
	logic [7:0]    wb;

	assign caddr   = avs_address[15:0];
	assign wb      = avs_writedata[7:0];
	assign arr     = avs_address[ARRAY_SEL];
	assign in_arr  = caddr >= BASE;
	assign key_hit = (caddr >= KEY_FIRST) && (caddr <= KEY_LAST);
	assign booting = (ex_q == EX_BOOT) || (ex_q == EX_BCAP);
	assign sweep   = (ex_q == EX_SWEEP);
	assign active  = (ex_q == EX_WAIT) || sweep || (ex_q == EX_CHECK);
	assign done    = empty_q && (ex_q == EX_IDLE);

	// bus handshake
	assign wr      = avs_write && !booting && avs_byteenable[0];
	assign rd_go   = avs_read && !booting && !(arr && sweep);
	assign rd_ack  = rd_go && (rd_cnt_q == (arr ? 2'h2 : 2'h1));
	assign avs_waitrequest = (booting && (avs_read || avs_write)) ||
		(avs_read && !rd_ack);

	assign wr_key  = wr && arr && keyen_q && key_hit;
	assign wr_arr  = wr && arr && !(keyen_q && key_hit);
	assign wr_cmd  = wr && !arr && (avs_address == A_COMMAND);
	assign wr_st   = wr && !arr && (avs_address == A_STATUS);
	assign wr_prot = wr && !arr && (avs_address == A_PROT);

	// command sequence checks
	assign arr_err = wr_arr && ((seq_q != SEQ_IDLE) || !empty_q || !in_arr);
	assign cmd_err = wr_cmd && ((seq_q != SEQ_DATA) || !fcps_legal(wb));
	assign launch_req = wr_st && wb[ST_EMPTY];
	assign launch_err = launch_req && ((seq_q != SEQ_CMD) || !empty_q ||
		((cmd_q != CMD_BLANK) && !div_set_q) ||
		(active && ((cmd_q != CMD_BURST) || (ec_q != CMD_BURST))));
	assign launch_pv  = launch_req && !launch_err &&
		fcps_prot_hit(sa_q, prot_q, cmd_q);
	assign launch_ok  = launch_req && !launch_err && !launch_pv;
	assign stop_abort = stop_s2_q && (active || !empty_q);
	assign acc_set    = arr_err || cmd_err || launch_err || stop_abort;
	assign xfer       = (ex_q == EX_IDLE) && !empty_q && !stop_abort;
	assign blank_done = (ex_q == EX_CHECK) && blank_ok_q && (mem_rdata == ERASED);

	// stop pin synchroniser
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
		end
		else
		begin
			stop_s1_q <= stop_req;
			stop_s2_q <= stop_s1_q;
		end
	end

	// flash clock enable
	assign tick = (!div_q[DIV_PRE] || (pre_q == PRE_LAST)) && (dcnt_q == div_q[5:0]);
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_q  <= 3'h0;
			dcnt_q <= 6'h00;
		end
		else
		begin
			pre_q <= pre_q + 3'h1;
			if (!div_q[DIV_PRE] || (pre_q == PRE_LAST))
				dcnt_q <= (dcnt_q == div_q[5:0]) ? 6'h00 : dcnt_q + 6'h01;
		end
	end

	// configuration and divider registers
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			keyen_q   <= 1'b0;
			div_q     <= 7'h00;
			div_set_q <= 1'b0;
		end
		else if (wr && !arr && (avs_address == A_CONFIG))
			keyen_q <= wb[CFG_KEYEN];
		else if (wr && !arr && (avs_address == A_DIVIDER))
		begin
			div_q     <= wb[6:0];
			div_set_q <= 1'b1;
		end
	end

	// protection register
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			prot_q <= PROT_RESET;
		else if (ex_q == EX_BCAP)
			prot_q <= mem_rdata;
		else if (wr_prot && !prot_q[PROT_DIS] && !wb[PROT_DIS] && (wb[7:1] <= prot_q[7:1]))
			prot_q <= wb;
	end

	// command sequence
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			seq_q <= SEQ_IDLE;
			sa_q  <= 16'h0000;
			sd_q  <= 8'h00;
			cmd_q <= 8'h00;
		end
		else if (arr_err || cmd_err || launch_req)
			seq_q <= SEQ_IDLE;
		else if (wr_arr)
		begin
			seq_q <= SEQ_DATA;
			sa_q  <= caddr;
			sd_q  <= wb;
		end
		else if (wr_cmd)
		begin
			seq_q <= SEQ_CMD;
			cmd_q <= wb;
		end
	end

	// command buffer
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			empty_q <= 1'b1;
			bc_q    <= 8'h00;
			ba_q    <= 16'h0000;
			bd_q    <= 8'h00;
		end
		else if (launch_ok)
		begin
			empty_q <= 1'b0;
			bc_q    <= cmd_q;
			ba_q    <= sa_q;
			bd_q    <= sd_q;
		end
		else if (xfer || stop_abort)
			empty_q <= 1'b1;
	end

	// error flags, set wins over clear
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pviol_q  <= 1'b0;
			accerr_q <= 1'b0;
		end
		else
		begin
			if (launch_pv)
				pviol_q <= 1'b1;
			else if (wr_st && wb[ST_PVIOL])
				pviol_q <= 1'b0;
			if (acc_set)
				accerr_q <= 1'b1;
			else if (wr_st && wb[ST_ACCERR])
				accerr_q <= 1'b0;
		end
	end

	// blank flag and security state
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			blank_q <= 1'b0;
			security_state_code <= SEC_RESET;
		end
		else if (launch_ok)
			blank_q <= 1'b0;
		else if (blank_done)
		begin
			blank_q <= 1'b1;
			security_state_code <= SEC_UNSEC;
		end
	end

	// array engine
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ex_q       <= EX_BOOT;
			ec_q       <= 8'h00;
			ea_q       <= '0;
			ed_q       <= 8'h00;
			pulse_q    <= 16'h0000;
			ptr_q      <= '0;
			end_q      <= '0;
			blank_ok_q <= 1'b0;
			chk_q      <= 1'b0;
		end
		else
		begin
			chk_q <= sweep && (ec_q == CMD_BLANK);
			if (chk_q && (mem_rdata != ERASED))
				blank_ok_q <= 1'b0;
			case (ex_q)
				EX_BOOT:
					ex_q <= EX_BCAP;
				EX_BCAP:
					ex_q <= EX_IDLE;
				EX_IDLE:
					if (xfer)
					begin
						ex_q       <= EX_WAIT;
						ec_q       <= bc_q;
						ea_q       <= ba_q[AW-1:0];
						ed_q       <= bd_q;
						blank_ok_q <= 1'b1;
						case (bc_q)
							CMD_PAGE:  pulse_q <= 16'(PAGE_PULSES);
							CMD_MASS:  pulse_q <= 16'(MASS_PULSES);
							CMD_BLANK: pulse_q <= 16'(BLNK_PULSES);
							default:   pulse_q <= 16'(PROG_PULSES);
						endcase
					end
				EX_WAIT:
					if (stop_abort)
						ex_q <= EX_IDLE;
					else if (tick)
					begin
						pulse_q <= pulse_q - 16'h0001;
						if (pulse_q <= 16'h0001)
						begin
							ex_q <= EX_SWEEP;
							case (ec_q)
								CMD_PAGE:
								begin
									ptr_q <= {ea_q[AW-1:PAGE_AW], PAGE_AW'(0)};
									end_q <= {ea_q[AW-1:PAGE_AW], {PAGE_AW{1'b1}}};
								end
								CMD_MASS, CMD_BLANK:
								begin
									ptr_q <= '0;
									end_q <= LAST;
								end
								default:
								begin
									ptr_q <= ea_q;
									end_q <= ea_q;
								end
							endcase
						end
					end
				EX_SWEEP:
					if (stop_abort)
						ex_q <= EX_IDLE;
					else
					begin
						ptr_q <= ptr_q + AW'(1);
						if (ptr_q == end_q)
							ex_q <= (ec_q == CMD_BLANK) ? EX_CHECK : EX_IDLE;
					end
				EX_CHECK:
					ex_q <= EX_IDLE;
				default:
					ex_q <= EX_IDLE;
			endcase
		end
	end

	// array access
	assign raddr = sweep ? ptr_q : (ex_q == EX_BOOT) ? NONVOLATILE_PROTECTION_BYTE_ADDR[AW-1:0] : caddr[AW-1:0];

	fcps_mem #(
		.DEPTH (ARRAY_BYTES),
		.AW    (AW)
	) u_mem (
		.mclk  (mclk),
		.we    (sweep && (ec_q != CMD_BLANK) && !stop_abort),
		.waddr (ptr_q),
		.wdata ((ec_q == CMD_PAGE || ec_q == CMD_MASS) ? ERASED : ed_q),
		.raddr (raddr),
		.rdata (mem_rdata)
	);

	// key window output
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			key_wr_valid <= 1'b0;
			key_wr_index <= 3'h0;
			key_wr_byte  <= 8'h00;
		end
		else
		begin
			key_wr_valid <= wr_key;
			if (wr_key)
			begin
				key_wr_index <= caddr[2:0];
				key_wr_byte  <= wb;
			end
		end
	end

	// read path
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_cnt_q     <= 2'h0;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			rd_cnt_q <= (!rd_go || rd_ack) ? 2'h0 : rd_cnt_q + 2'h1;
			if (rd_go && arr && (rd_cnt_q == 2'h1))
				avs_readdata <= {24'h000000, mem_rdata};
			else if (rd_go && !arr && (rd_cnt_q == 2'h0))
				case (avs_address)
					A_CONFIG:   avs_readdata <= {26'h0, keyen_q, 5'h00};
					A_DIVIDER:  avs_readdata <= {24'h0, div_set_q, div_q};
					A_PROT:     avs_readdata <= {24'h0, prot_q};
					A_STATUS:   avs_readdata <= {24'h0, empty_q, done, pviol_q,
						accerr_q, 1'b0, blank_q, 2'h0};
					A_COMMAND:  avs_readdata <= {24'h0, cmd_q};
					A_SECURITY: avs_readdata <= {30'h0, security_state_code};
					default:    avs_readdata <= 32'h00000000;
				endcase
		end
	end

	AST_KEY_NO_SEQ: assert property
		(@(posedge mclk) disable iff (!resetn) wr_key |=> $stable(seq_q))
		else $error("key window write changed command sequence");
	AST_KEY_CMD: assert property
		(@(posedge mclk) disable iff (!resetn)
		wr_arr && !arr_err |=> seq_q == SEQ_DATA && sa_q == $past(caddr))
		else $error("array write did not start command");
	AST_BOOT_LOAD: assert property
		(@(posedge mclk) disable iff (!resetn) ex_q == EX_BCAP |=> prot_q == $past(mem_rdata))
		else $error("protection not loaded from nonvolatile byte");
	AST_PROT_SHRINK: assert property
		(@(posedge mclk) disable iff (!resetn)
		!booting && !prot_q[PROT_DIS] |=> !prot_q[PROT_DIS] && prot_q[7:1] <= $past(prot_q[7:1]))
		else $error("protection was reduced");
	AST_PROT_DIS: assert property
		(@(posedge mclk) disable iff (!resetn)
		!booting && prot_q[PROT_DIS] |=> $stable(prot_q))
		else $error("protection changed while disabled");
	AST_LAUNCH: assert property
		(@(posedge mclk) disable iff (!resetn)
		launch_ok |=> !empty_q && !done ##1 (ex_q == EX_WAIT) || !empty_q)
		else $error("launch did not clear empty or reach engine");
	AST_PVIOL: assert property
		(@(posedge mclk) disable iff (!resetn)
		launch_pv |=> pviol_q && empty_q == $past(empty_q) && seq_q == SEQ_IDLE)
		else $error("protected command not discarded");
	AST_ILLEGAL: assert property
		(@(posedge mclk) disable iff (!resetn)
		wr_cmd && seq_q == SEQ_DATA && !fcps_legal(wb) |=> accerr_q && seq_q == SEQ_IDLE)
		else $error("illegal command accepted");
	AST_BLANK_CLR: assert property
		(@(posedge mclk) disable iff (!resetn) launch_ok |=> !blank_q)
		else $error("blank flag not cleared by launch");
	AST_UNSEC: assert property
		(@(posedge mclk) disable iff (!resetn)
		blank_done |=> security_state_code == SEC_UNSEC && blank_q && done)
		else $error("blank check did not unsecure");
endmodule // fcps_core

// File: tb/tb_top.sv
// Purpose: self-checking bench for the flash command, protection and status block
// Assumes: register map and wait states of fcps_core
// Notes: shortened pulse counts, divider 0, byteenable driven by the bench
`timescale 1ns/1ns
module tb_top;
	import fcps_pkg::*;
	logic        mclk;
	logic        resetn;
	logic [16:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        stop_req;
	logic        key_wr_valid;
	logic [2:0]  key_wr_index;
	logic [7:0]  key_wr_byte;
	logic [1:0]  security_state_code;
	int          miscompares;
	int          check_count;
	int          key_cnt;
	logic [2:0]  key_idx;
	logic [7:0]  key_dat;

	fcps_core #(
		.ARRAY_BYTES(1024),
		.PROG_PULSES(8),
		.PAGE_PULSES(8),
		.MASS_PULSES(8),
		.BLNK_PULSES(1)
	) dut (
		.mclk                (mclk),
		.resetn              (resetn),
		.avs_address         (avs_address),
		.avs_read            (avs_read),
		.avs_write           (avs_write),
		.avs_writedata       (avs_writedata),
		.avs_byteenable      (avs_byteenable),
		.avs_readdata        (avs_readdata),
		.avs_waitrequest     (avs_waitrequest),
		.stop_req            (stop_req),
		.key_wr_valid        (key_wr_valid),
		.key_wr_index        (key_wr_index),
		.key_wr_byte         (key_wr_byte),
		.security_state_code (security_state_code)
	);

	always #5 mclk = ~mclk;

	// key pulse monitor, sampled mid-cycle
	always @(negedge mclk)
		if (key_wr_valid === 1'b1)
		begin
			key_cnt = key_cnt + 1;
			key_idx = key_wr_index;
			key_dat = key_wr_byte;
		end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// called just after a rising edge; one idle edge after each transfer
	task automatic bus_wr(input logic [16:0] a, input logic [7:0] d);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= 1'b1;
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic bus_rd(input logic [16:0] a, output logic [7:0] d);
		avs_address <= a;
		avs_read    <= 1'b1;
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		d = avs_readdata[7:0];
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bus_rd(a, d);
		check(d, exp);
	endtask

	task automatic wait_done();
		logic [7:0] s;
		s = 8'h00;
		while (s[ST_DONE] !== 1'b1)
			bus_rd(A_STATUS, s);
	endtask

	// data byte, command code, launch, then poll for completion
	task automatic run(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
		bus_wr({1'b1, a}, d);
		bus_wr(A_COMMAND, c);
		bus_wr(A_STATUS, 8'h80);
		wait_done();
	endtask

	task automatic do_reset();
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		tally_and_finish();
	end

	initial
	begin
		mclk = 1'b0;
		resetn = 1'b0;
		avs_address = 17'h00000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		stop_req = 1'b0;
		miscompares = 0;
		check_count = 0;
		key_cnt = 0;
		key_idx = 3'h0;
		key_dat = 8'h00;
		do_reset();
		rd_chk(A_PROT, 8'hFF);
		rd_chk(A_STATUS, 8'hC0);
		rd_chk(A_SECURITY, 8'h00);
		rd_chk(17'h00006, 8'h00);
		bus_wr(A_PROT, 8'h80);
		rd_chk(A_PROT, 8'hFF);
		// key window with key-write enable set
		bus_wr(A_CONFIG, 8'h20);
		bus_wr(17'h1FFB3, 8'hA5);
		rd_chk(A_STATUS, 8'hC0);
		check(8'(key_cnt), 8'h01);
		check({5'h00, key_idx}, 8'h03);
		check(key_dat, 8'hA5);
		bus_wr(A_CONFIG, 8'h00);
		// key window as command start, divider not yet written
		run(16'hFFB0, 8'h12, CMD_BYTE);
		rd_chk(A_STATUS, 8'hD0);
		check(8'(key_cnt), 8'h01);
		bus_wr(A_STATUS, 8'h00);
		rd_chk(A_STATUS, 8'hD0);
		bus_wr(A_STATUS, 8'h10);
		rd_chk(A_STATUS, 8'hC0);
		// write without lane 0 enabled is ignored
		avs_byteenable <= 4'hE;
		bus_wr(A_DIVIDER, 8'h00);
		avs_byteenable <= 4'hF;
		rd_chk(A_DIVIDER, 8'h00);
		bus_wr(A_DIVIDER, 8'h00);
		rd_chk(A_DIVIDER, 8'h80);
		// command without data byte
		bus_wr(A_COMMAND, CMD_BYTE);
		rd_chk(A_STATUS, 8'hD0);
		bus_wr(A_STATUS, 8'h10);
		bus_wr(17'h1FC00, 8'h00);
		bus_wr(A_COMMAND, 8'h33);
		rd_chk(A_STATUS, 8'hD0);
		bus_wr(A_STATUS, 8'h10);
		run(16'hFC00, 8'h00, CMD_BLANK);
		rd_chk(A_STATUS, 8'hC4);
		rd_chk(A_SECURITY, 8'h02);
		bus_wr(A_STATUS, 8'h44);
		rd_chk(A_STATUS, 8'hC4);
		run(16'hFC10, 8'h5A, CMD_BYTE);
		rd_chk(A_STATUS, 8'hC0);
		rd_chk(17'h1FC10, 8'h5A);
		rd_chk(A_COMMAND, CMD_BYTE);
		run(16'hFC00, 8'h00, CMD_BLANK);
		rd_chk(A_STATUS, 8'hC0);
		// two burst programs back to back, second buffered
		bus_wr(17'h1FE20, 8'h11);
		bus_wr(A_COMMAND, CMD_BURST);
		bus_wr(A_STATUS, 8'h80);
		bus_wr(17'h1FE21, 8'h22);
		bus_wr(A_COMMAND, CMD_BURST);
		bus_wr(A_STATUS, 8'h80);
		rd_chk(A_STATUS, 8'h00);
		wait_done();
		rd_chk(A_STATUS, 8'hC0);
		rd_chk(17'h1FE20, 8'h11);
		rd_chk(17'h1FE21, 8'h22);
		run(16'hFC00, 8'h00, CMD_PAGE);
		rd_chk(17'h1FC10, 8'hFF);
		rd_chk(17'h1FE20, 8'h11);
		run(16'hFE00, 8'h00, CMD_MASS);
		rd_chk(17'h1FE20, 8'hFF);
		run(16'hFC00, 8'h00, CMD_BLANK);
		rd_chk(A_STATUS, 8'hC4);
		// stop entry aborts a running erase
		bus_wr(17'h1FC00, 8'h00);
		bus_wr(A_COMMAND, CMD_PAGE);
		bus_wr(A_STATUS, 8'h80);
		stop_req <= 1'b1;
		repeat (4) @(posedge mclk);
		stop_req <= 1'b0;
		wait_done();
		rd_chk(A_STATUS, 8'hD0);
		bus_wr(A_STATUS, 8'h10);
		// nonvolatile protection byte: boundary 0x7E, enabled
		run(NONVOLATILE_PROTECTION_BYTE_ADDR, 8'hFC, CMD_BYTE);
		do_reset();
		rd_chk(A_PROT, 8'hFC);
		rd_chk(A_SECURITY, 8'h00);
		rd_chk(A_STATUS, 8'hC0);
		bus_wr(A_DIVIDER, 8'h00);
		run(16'hFE10, 8'h00, CMD_BYTE);
		rd_chk(A_STATUS, 8'hE0);
		rd_chk(17'h1FE10, 8'hFF);
		bus_wr(A_STATUS, 8'h20);
		rd_chk(A_STATUS, 8'hC0);
		run(16'hFC00, 8'h00, CMD_MASS);
		rd_chk(A_STATUS, 8'hE0);
		bus_wr(A_STATUS, 8'h20);
		run(16'hFC40, 8'h33, CMD_BYTE);
		rd_chk(A_STATUS, 8'hC0);
		rd_chk(17'h1FC40, 8'h33);
		bus_wr(A_PROT, 8'hFE);
		rd_chk(A_PROT, 8'hFC);
		bus_wr(A_PROT, 8'hFA);
		rd_chk(A_PROT, 8'hFA);
		bus_wr(A_PROT, 8'hF9);
		rd_chk(A_PROT, 8'hFA);
		run(16'hFC50, 8'h00, CMD_BYTE);
		rd_chk(A_STATUS, 8'hE0);
		rd_chk(17'h1FC50, 8'hFF);
		tally_and_finish();
	end
endmodule // tb_top
